// ===== rtl/sipo_pkg.sv
package sipo_pkg;
	localparam int SIPO_WIDTH     = 8;
	localparam logic [7:0] SIPO_RST_STAGES  = 8'h00;
	localparam logic [7:0] SIPO_RST_STORAGE = 8'h00;
	localparam int SIPO_SYNC_DEPTH = 2;
endpackage

// ===== rtl/sipo_if.sv
`timescale 1ns/1ns
interface sipo_if;
	logic i_raw;
	logic o_level;
	logic o_rise;
	modport sync (input i_raw, output o_level, output o_rise);
	modport user (output i_raw, input o_level, input o_rise);
endinterface

// ===== rtl/sipo_sync.sv
`timescale 1ns/1ns
module sipo_sync
	import sipo_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_rst,
	sipo_if.sync      port
);
	typedef struct packed {
		logic meta;
		logic level;
		logic prev;
		logic rise;
	} sipo_sync_t;

	sipo_sync_t st;
	sipo_sync_t next_st;

	// meta feeds only level; reading meta elsewhere risks metastable edges
	always_comb begin
		next_st       = st;
		next_st.meta  = port.i_raw;
		next_st.level = st.meta;
		next_st.prev  = st.level;
		next_st.rise  = st.level & ~st.prev;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign port.o_level = st.level;
	assign port.o_rise  = st.rise;
endmodule

// ===== rtl/sipo_latch.sv
`timescale 1ns/1ns
module sipo_latch
	import sipo_pkg::*;
#(
	parameter int WIDTH = SIPO_WIDTH
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_serial_in,
	input  wire logic             i_shift_clock,
	input  wire logic             i_storage_load_clock,
	input  wire logic             i_shift_clear_n,
	input  wire logic             i_output_enable_n,
	output logic [WIDTH-1:0]      o_parallel_out,
	output logic [WIDTH-1:0]      o_parallel_out_en_n,
	output logic                  o_serial_cascade_out
);
	sipo_if sck_if ();
	sipo_if rck_if ();

	// clocks arrive from the pins; edges found after three flops
	assign sck_if.i_raw = i_shift_clock;
	assign rck_if.i_raw = i_storage_load_clock;

	sipo_sync u_sck (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.port  (sck_if)
	);
	sipo_sync u_rck (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.port  (rck_if)
	);

	typedef struct packed {
		logic [1:0]       si_sync;
		logic [1:0]       clr_sync;
		logic [1:0]       oe_sync;
		logic             si_d;
		logic [WIDTH-1:0] shift_stages;
		logic [WIDTH-1:0] storage_bits;
		logic [WIDTH-1:0] par_out;
		logic [WIDTH-1:0] par_en_n;
		logic             cascade;
	} sipo_state_t;

	sipo_state_t st;
	sipo_state_t next_st;

	always_comb begin
		next_st          = st;
		next_st.si_sync  = {st.si_sync[0], i_serial_in};
		next_st.clr_sync = {st.clr_sync[0], i_shift_clear_n};
		next_st.oe_sync  = {st.oe_sync[0], i_output_enable_n};
		// serial data delayed one more so it matches the edge detector
		next_st.si_d     = st.si_sync[1];
		if (!st.clr_sync[1]) begin
			next_st.shift_stages = '0;
		end else if (sck_if.o_rise) begin
			next_st.shift_stages = {st.shift_stages[WIDTH-2:0],
				st.si_d};
		end
		// storage only moves on its own edge, old stages taken
		if (rck_if.o_rise) begin
			next_st.storage_bits = st.shift_stages;
		end
		next_st.cascade  = next_st.shift_stages[WIDTH-1];
		next_st.par_out  = next_st.storage_bits;
		next_st.par_en_n = {WIDTH{st.oe_sync[1]}};
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st              <= '0;
			st.oe_sync      <= 2'h3;
			st.clr_sync     <= 2'h3;
			st.shift_stages <= SIPO_RST_STAGES;
			st.storage_bits <= SIPO_RST_STORAGE;
			st.par_en_n     <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign o_parallel_out       = st.par_out;
	assign o_parallel_out_en_n  = st.par_en_n;
	assign o_serial_cascade_out = st.cascade;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_clear_forces_low: assert property (
		!st.clr_sync[1] |=> st.shift_stages == '0 && !o_serial_cascade_out)
		else $error("clear did not empty stages");
	a_shift_moves: assert property (
		st.clr_sync[1] && sck_if.o_rise |=>
		st.shift_stages == {$past(st.shift_stages[WIDTH-2:0]), $past(st.si_d)})
		else $error("shift edge did not shift");
	a_load_copies: assert property (
		rck_if.o_rise |=> st.storage_bits == $past(st.shift_stages))
		else $error("load edge did not copy stages");
	a_storage_holds: assert property (
		!rck_if.o_rise |=> $stable(st.storage_bits))
		else $error("storage changed without load edge");
	a_out_follows: assert property (
		!rck_if.o_rise |=> $stable(o_parallel_out))
		else $error("outputs moved during shifting");
	a_enable_float: assert property (
		st.oe_sync[1] |=> o_parallel_out_en_n == '1)
		else $error("outputs not floated");
	a_enable_drive: assert property (
		!st.oe_sync[1] |=> o_parallel_out_en_n == '0)
		else $error("outputs not driven");
	a_cascade_last: assert property (
		##1 o_serial_cascade_out == st.shift_stages[WIDTH-1])
		else $error("cascade out not last stage");
	a_out_storage: assert property (
		o_parallel_out == st.storage_bits || $changed(st.storage_bits))
		else $error("outputs not storage");

	c_shift: cover property (st.clr_sync[1] && sck_if.o_rise);
	c_load: cover property (rck_if.o_rise);
	c_clear: cover property (!st.clr_sync[1]);
	c_float: cover property (st.oe_sync[1] ##1 !st.oe_sync[1]);
endmodule

// ===== sim/sipo_ctl.sv
`timescale 1ns/1ns
module sipo_ctl (
	output logic o_sdi = 1'b0,
	output logic o_sck = 1'b0,
	output logic o_rck = 1'b0
);
	// clock stands still between frames; msb goes first
	task automatic send(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			o_sdi = d[i];
			#40 o_sck = 1'b1;
			#40 o_sck = 1'b0;
		end
		o_sdi = ~o_sdi;
	endtask
	task automatic load();
		o_rck = 1'b1;
		#40 o_rck = 1'b0;
	endtask
endmodule

// ===== sim/sipo_latch_tb.sv
`timescale 1ns/1ns
module sipo_latch_tb;
	logic       i_clk = 1'b0;
	logic       i_rst = 1'b1;
	logic       clr_n = 1'b1;
	logic       oe_n  = 1'b0;
	logic       sdi, sck, storage_load_clock, cas;
	logic [7:0] po, en_n;
	int         n_mismatch  = 0;
	int         check_count = 0;
	always #2 i_clk = ~i_clk;
	sipo_ctl CTL (.o_sdi(sdi), .o_sck(sck), .o_rck(storage_load_clock));
	sipo_latch DUT (.i_clk(i_clk), .i_rst(i_rst), .i_serial_in(sdi),
		.i_shift_clock(sck), .i_storage_load_clock(storage_load_clock),
		.i_shift_clear_n(clr_n), .i_output_enable_n(oe_n),
		.o_parallel_out(po), .o_parallel_out_en_n(en_n),
		.o_serial_cascade_out(cas));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// synchronisers need about four cycles
	task automatic settle();
		repeat (8) @(negedge i_clk);
	endtask
	task automatic shift_and_hold();
		CTL.send(8'hA5);
		settle();
		check(po, 8'h00);
		check({7'h00, cas}, 8'h01);
		CTL.load();
		settle();
		check(po, 8'hA5);
		check(en_n, 8'h00);
		CTL.send(8'h3C);
		settle();
		check(po, 8'hA5);
		check({7'h00, cas}, 8'h00);
		CTL.load();
		settle();
		check(po, 8'h3C);
	endtask
	task automatic float_outputs();
		oe_n = 1'b1;
		settle();
		check(en_n, 8'hFF);
		oe_n = 1'b0;
		settle();
		check(en_n, 8'h00);
		check(po, 8'h3C);
	endtask
	task automatic clear_blocks_shift();
		clr_n = 1'b0;
		CTL.send(8'hFF);
		settle();
		check({7'h00, cas}, 8'h00);
		check(po, 8'h3C);
		clr_n = 1'b1;
		CTL.load();
		settle();
		check(po, 8'h00);
	endtask
	// whole run is about 2.3 microseconds
	initial begin
		#20000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		repeat (5) @(negedge i_clk);
		i_rst = 1'b0;
		settle();
		shift_and_hold();
		float_outputs();
		clear_blocks_shift();
		end_of_test();
	end
endmodule
